//--- sarsc_consts.vh
// Purpose: Shared constants of the serial converter control block.
// Assumes: Included by bare name from the top module's design file.
// Notes: Definitions only; no logic lives here.
`ifndef SARSC_CONSTS_VH
`define SARSC_CONSTS_VH

// Result and configuration word widths.
`define SARSC_RES_BITS 12
`define SARSC_CFG_BITS 6

// Configuration word bit positions; the first bit received lands at 5.
`define SARSC_CFG_SINGLE 5
`define SARSC_CFG_ODD 4
`define SARSC_CFG_RANGE 1

// Configuration bit counter width and the count of captured bits.
`define SARSC_CFGCNT_W 3
`define SARSC_CFG_COUNT 3'h6

// Clock rate in MHz and typical conversion time in ns.
`define SARSC_CLK_MHZ 10
`define SARSC_CONV_TIME_NS 1300

// Conversion cycle count, rounded up to whole cycles.
`define SARSC_CONV_CYCLES \
    ((`SARSC_CONV_TIME_NS * `SARSC_CLK_MHZ + 999) / 1000)
`define SARSC_CONVCNT_W 5

// Reset values and the first trial code.
`define SARSC_RES_RESET 12'h000
`define SARSC_CFG_RESET 6'h00
`define SARSC_MSB_TRIAL 12'h800

`endif

//--- sarsc_sync.v
// Purpose: Two-flop synchroniser for one pin input.
// Assumes: Synchronous active-low reset on clk.
// Notes: Only the second flop is visible outside.
`timescale 1ns/100ps
`default_nettype none

module sarsc_sync
#(
    parameter RESET_VALUE = 1'b0
)
(
    // Clock and reset.
    input wire clk,
    input wire reset_n,
    // Asynchronous input and its synchronised copy.
    input wire async_in,
    output wire sync_out
);

reg meta_q;
reg sync_q;

// The first flop feeds only the second one.
always @(posedge clk)
begin
    if (!reset_n)
    begin
        meta_q <= RESET_VALUE;
        sync_q <= RESET_VALUE;
    end
    else
    begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end

assign sync_out = sync_q;

endmodule // sarsc_sync

`default_nettype wire

//--- sarsc_top.v
// Purpose: Digital control of a 12-bit successive-approximation converter.
// Assumes: Serial clock, data in and conversion start are slow pins.
// Notes: The analog comparator answer arrives on clk, unsynchronised.
// Behaviour
// - Serial output carries the most recently completed result.
// - Output advances one result bit on each serial clock fall.
// - Output driven only while conversion start is low.
// - A rising edge of conversion start while idle begins a conversion.
// - Data in sampled on rising clock of the first six pulses only.
// - Start edges during a running conversion are ignored.
// - Result shifts out on the same pulses that load configuration.
// - After the sixth bit, acquisition begins while output continues.
// - Bits resolve MSB first, then latch into the output register.
// - Word: single, odd, two ignored, range, one ignored; first first.
// - Don't-care positions have no effect on configuration.
// - One-input variant ignores the single bit.
// - Two-input mux: differential pairs or single input to ground.
// - One-input variant: odd bit swaps input polarity.
// - Positive and negative inputs are sampled at the same instant.
// - Bipolar output is two's complement, unipolar straight binary.
// - Start still high at conversion end sleeps until it falls.
// - Start low at conversion end presents MSB and stays awake.
`timescale 1ns/100ps
`default_nettype none
`include "sarsc_consts.vh"

module sarsc_top
#(
    parameter TWO_INPUTS = 1'b1
)
(
    // Clock and reset.
    input wire clk,
    input wire reset_n,
    // Serial port pins.
    input wire sck_in,
    input wire sdi_in,
    input wire conversion_start_in,
    output wire sdo_out,
    output wire sdo_oe,
    // Analog front end control.
    input wire comp_high_in,
    output wire [`SARSC_RES_BITS-1:0] dac_code_out,
    output wire sample_strobe_out,
    output wire acquiring_out,
    output wire analog_input_zero_pos,
    output wire analog_input_one_pos,
    output wire analog_input_one_neg,
    output wire negative_is_ground,
    output wire range_select,
    // Status.
    output wire busy_out,
    output wire sleep_out
);

localparam integer CONV_LAST_I = `SARSC_CONV_CYCLES - 1;
localparam [`SARSC_CONVCNT_W-1:0] CONV_LAST =
    CONV_LAST_I[`SARSC_CONVCNT_W-1:0];

wire sck_s;
wire sdi_s;
wire start_s;
reg sck_prev_q;
reg start_prev_q;
reg busy_q;
reg sleep_q;
reg acquiring_q;
reg sample_q;
reg [`SARSC_CONVCNT_W-1:0] conv_cnt_q;
reg [`SARSC_RES_BITS-1:0] sar_q;
reg [`SARSC_RES_BITS-1:0] mask_q;
reg [`SARSC_RES_BITS-1:0] result_q;
reg [`SARSC_RES_BITS-1:0] shift_q;
reg [`SARSC_CFG_BITS-1:0] cfg_shift_q;
reg [`SARSC_CFGCNT_W-1:0] cfg_cnt_q;
reg single_q;
reg odd_q;
reg range_q;
reg conv_range_q;
wire sck_rise;
wire sck_fall;
wire start_rise;
wire start_fall;
wire conv_done;
wire [`SARSC_CFG_BITS-1:0] cfg_word;
wire [`SARSC_RES_BITS-1:0] mask_next;
wire [`SARSC_RES_BITS-1:0] sar_kept;
wire [`SARSC_RES_BITS-1:0] formatted;

// Pin synchronisers.
sarsc_sync #(.RESET_VALUE(1'b0)) u_sync_sck
(
    .clk(clk),
    .reset_n(reset_n),
    .async_in(sck_in),
    .sync_out(sck_s)
);

sarsc_sync #(.RESET_VALUE(1'b0)) u_sync_sdi
(
    .clk(clk),
    .reset_n(reset_n),
    .async_in(sdi_in),
    .sync_out(sdi_s)
);

sarsc_sync #(.RESET_VALUE(1'b0)) u_sync_start
(
    .clk(clk),
    .reset_n(reset_n),
    .async_in(conversion_start_in),
    .sync_out(start_s)
);

// Edge detection on the synchronised pins.
always @(posedge clk)
begin
    if (!reset_n)
    begin
        sck_prev_q <= 1'b0;
        start_prev_q <= 1'b0;
    end
    else
    begin
        sck_prev_q <= sck_s;
        start_prev_q <= start_s;
    end
end

assign sck_rise = sck_s & ~sck_prev_q;
assign sck_fall = ~sck_s & sck_prev_q;
assign start_rise = start_s & ~start_prev_q;
assign start_fall = ~start_s & start_prev_q;

// Conversion ends on the cycle after the last bit decision.
assign conv_done = busy_q && (conv_cnt_q == CONV_LAST);

// Conversion sequencer; a start edge while busy is dropped.
always @(posedge clk)
begin
    if (!reset_n)
    begin
        busy_q <= 1'b0;
        conv_cnt_q <= {`SARSC_CONVCNT_W{1'b0}};
        sample_q <= 1'b0;
        conv_range_q <= 1'b0;
    end
    else
    begin
        sample_q <= 1'b0;
        if (start_rise && !busy_q)
        begin
            busy_q <= 1'b1;
            conv_cnt_q <= {`SARSC_CONVCNT_W{1'b0}};
            sample_q <= 1'b1;
            conv_range_q <= range_q;
        end
        else if (conv_done)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q)
        begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
        end
    end
end

// Successive approximation, most significant trial first.
assign mask_next = mask_q >> 1;
assign sar_kept = comp_high_in ? sar_q : (sar_q & ~mask_q);

always @(posedge clk)
begin
    if (!reset_n)
    begin
        sar_q <= `SARSC_RES_RESET;
        mask_q <= `SARSC_RES_RESET;
    end
    else if (start_rise && !busy_q)
    begin
        sar_q <= `SARSC_MSB_TRIAL;
        mask_q <= `SARSC_MSB_TRIAL;
    end
    else if (busy_q && (mask_q != `SARSC_RES_RESET))
    begin
        sar_q <= sar_kept | mask_next;
        mask_q <= mask_next;
    end
end

// Bipolar offset code becomes two's complement by inverting the MSB.
assign formatted = conv_range_q ? sar_q :
    {~sar_q[`SARSC_RES_BITS-1], sar_q[`SARSC_RES_BITS-2:0]};

// Output latch, sleep state and serial shifter.
always @(posedge clk)
begin
    if (!reset_n)
    begin
        result_q <= `SARSC_RES_RESET;
        shift_q <= `SARSC_RES_RESET;
        sleep_q <= 1'b0;
    end
    else
    begin
        if (conv_done)
        begin
            result_q <= formatted;
            if (start_s)
            begin
                sleep_q <= 1'b1;
            end
            else
            begin
                shift_q <= formatted;
            end
        end
        else if (start_fall && !busy_q)
        begin
            sleep_q <= 1'b0;
            shift_q <= result_q;
        end
        else if (sck_fall && !start_s && !busy_q)
        begin
            shift_q <= {shift_q[`SARSC_RES_BITS-2:0], 1'b0};
        end
    end
end

// Configuration capture on the first six rising clocks of a frame.
assign cfg_word = {cfg_shift_q[`SARSC_CFG_BITS-2:0], sdi_s};

always @(posedge clk)
begin
    if (!reset_n)
    begin
        cfg_shift_q <= `SARSC_CFG_RESET;
        cfg_cnt_q <= {`SARSC_CFGCNT_W{1'b0}};
        single_q <= 1'b0;
        odd_q <= 1'b0;
        range_q <= 1'b0;
        acquiring_q <= 1'b0;
    end
    else
    begin
        if (start_rise && !busy_q)
        begin
            acquiring_q <= 1'b0;
        end
        if (start_s || busy_q)
        begin
            cfg_cnt_q <= {`SARSC_CFGCNT_W{1'b0}};
        end
        else if (sck_rise && (cfg_cnt_q < `SARSC_CFG_COUNT))
        begin
            cfg_shift_q <= cfg_word;
            cfg_cnt_q <= cfg_cnt_q + 1'b1;
            if (cfg_cnt_q == `SARSC_CFG_COUNT - 1'b1)
            begin
                // Only the meaningful positions are taken; others drop.
                single_q <= TWO_INPUTS ?
                    cfg_word[`SARSC_CFG_SINGLE] : 1'b0;
                odd_q <= cfg_word[`SARSC_CFG_ODD];
                range_q <= cfg_word[`SARSC_CFG_RANGE];
                acquiring_q <= 1'b1;
            end
        end
    end
end

// Input multiplexer decode.
assign analog_input_zero_pos = ~odd_q;
assign analog_input_one_pos = odd_q;
assign analog_input_one_neg = ~odd_q & ~single_q;
assign negative_is_ground = single_q;
assign range_select = busy_q ? conv_range_q : range_q;

// Pin and status outputs.
assign sdo_out = shift_q[`SARSC_RES_BITS-1];
assign sdo_oe = ~start_s & ~busy_q;
assign dac_code_out = sar_q;
assign sample_strobe_out = sample_q;
assign acquiring_out = acquiring_q;
assign busy_out = busy_q;
assign sleep_out = sleep_q;

endmodule // sarsc_top

`default_nettype wire

//--- sarsc_top_sva.sv
// Purpose: Port checks of the converter control block.
// Assumes: Sees only the top module's ports.
// Notes: Bound into the top module below.
`timescale 1ns/100ps
`default_nettype none
module sarsc_sva
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Serial pins.
    input wire logic sck_in,
    input wire logic conversion_start_in,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // Converter outputs.
    input wire logic [11:0] dac_code_out,
    input wire logic sample_strobe_out,
    input wire logic acquiring_out,
    input wire logic analog_input_zero_pos,
    input wire logic analog_input_one_pos,
    input wire logic busy_out,
    input wire logic sleep_out
);
    // All checks run on the block clock and rest in reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    start_ok_a:
    assert property ($rose(busy_out) |-> sample_strobe_out
        && dac_code_out == 12'h800) else $error("Bad start.");
    busy_len_a:
    assert property ($rose(busy_out) |-> ##12 busy_out ##1 !busy_out)
        else $error("Bad conversion length.");
    strobe_once_a:
    assert property (sample_strobe_out |-> $rose(busy_out))
        else $error("Stray sample.");
    oe_off_a:
    assert property (conversion_start_in [*4] |-> !sdo_oe)
        else $error("Output driven while start high.");
    oe_on_a:
    assert property ((!conversion_start_in) [*4] ##0 !busy_out |-> sdo_oe)
        else $error("Output released while start low.");
    shift_fall_a:
    assert property ($changed(sdo_out) && sdo_oe && $past(sdo_oe)
        && !$past(busy_out) |-> !$past(sck_in, 2))
        else $error("Output moved without a clock fall.");
    acq_a:
    assert property ($rose(acquiring_out) |-> !busy_out)
        else $error("Acquire during conversion.");
    sleep_a:
    assert property ($fell(busy_out) && conversion_start_in |-> ##[0:1]
        sleep_out) else $error("No sleep.");
    // The mux may only move in a cycle in which acquisition is flagged.
    mux_a:
    assert property ($changed(analog_input_one_pos) |-> acquiring_out)
        else $error("Bad mux.");
endmodule // sarsc_sva
bind sarsc_top sarsc_sva sarsc_sva_inst (.clk(clk), .reset_n(reset_n),
    .sck_in(sck_in), .conversion_start_in(conversion_start_in),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .dac_code_out(dac_code_out),
    .sample_strobe_out(sample_strobe_out), .acquiring_out(acquiring_out),
    .analog_input_zero_pos(analog_input_zero_pos),
    .analog_input_one_pos(analog_input_one_pos), .busy_out(busy_out),
    .sleep_out(sleep_out));
`default_nettype wire

//--- sarsc_host.sv
// Purpose: Serial host that drives start, clock and data pins.
// Assumes: Pins change on the bench clock's falling edge.
// Notes: Serial clock period is eight bench cycles, idle low.
`timescale 1ns/100ps
`default_nettype none
module sarsc_host
(
    // Bench clock and the device's serial output.
    input wire logic clk,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // Pins towards the device.
    output logic sck_in,
    output logic sdi_in,
    output logic conversion_start_in
);
    // A released line shows the opposite of its last level.
    wire line = sdo_oe ? sdo_out : ~sdo_out;
    initial
    begin
        sck_in = 1'b0;
        sdi_in = 1'b0;
        conversion_start_in = 1'b0;
    end
    // Start held high past the conversion; poke tries a restart.
    task convert(input logic poke);
    begin
        @(negedge clk);
        conversion_start_in = 1'b1;
        repeat (5) @(negedge clk);
        if (poke)
        begin
            conversion_start_in = 1'b0;
            @(negedge clk);
            conversion_start_in = 1'b1;
        end
        repeat (16) @(negedge clk);
    end
    endtask
    // Short start pulse: start falls mid-conversion so the converter
    // stays awake; the quiet window is traded for reaching that path.
    task pulse;
    begin
        @(negedge clk);
        conversion_start_in = 1'b1;
        repeat (3) @(negedge clk);
        conversion_start_in = 1'b0;
        repeat (18) @(negedge clk);
    end
    endtask
    // Twelve pulses: six word bits, then inverted filler bits.
    task xfer(input logic [5:0] cfg, output logic [11:0] got);
        integer i;
    begin
        @(negedge clk);
        conversion_start_in = 1'b0;
        got = 12'h000;
        for (i = 0; i < 12; i = i + 1)
        begin
            sdi_in = (i < 6) ? cfg[5 - i] : ~cfg[11 - i];
            repeat (4) @(negedge clk);
            sck_in = 1'b1;
            got = {got[10:0], line};
            repeat (4) @(negedge clk);
            sck_in = 1'b0;
        end
        repeat (4) @(negedge clk);
    end
    endtask
endmodule // sarsc_host
`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench of the converter control block.
// Assumes: Comparator is modelled from a fixed input code.
// Notes: Results are read one transfer after each conversion.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, reset_n, comp_high_in;
    logic [11:0] vin, got;
    integer n_mismatch, check_count;
    integer busy_cycles = 0;
    wire sck_in, sdi_in, conversion_start_in, sdo_out, sdo_oe;
    wire sample_strobe_out, acquiring_out, analog_input_zero_pos;
    wire analog_input_one_pos, analog_input_one_neg, negative_is_ground;
    wire range_select, busy_out, sleep_out;
    wire [11:0] dac_code_out;
    sarsc_top sarsc_top_inst (.clk(clk), .reset_n(reset_n),
        .sck_in(sck_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
        .conversion_start_in(conversion_start_in), .sdo_oe(sdo_oe),
        .comp_high_in(comp_high_in), .dac_code_out(dac_code_out),
        .sample_strobe_out(sample_strobe_out),
        .acquiring_out(acquiring_out), .range_select(range_select),
        .analog_input_zero_pos(analog_input_zero_pos),
        .analog_input_one_pos(analog_input_one_pos),
        .analog_input_one_neg(analog_input_one_neg),
        .negative_is_ground(negative_is_ground), .busy_out(busy_out),
        .sleep_out(sleep_out));
    sarsc_host sarsc_host_inst (.clk(clk), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .sck_in(sck_in), .sdi_in(sdi_in),
        .conversion_start_in(conversion_start_in));
    // Comparator answers whether the input reaches the trial code.
    always @(negedge clk)
        comp_high_in <= (vin >= dac_code_out);
    // Counts the cycles in which a conversion runs.
    always @(posedge clk)
        if (busy_out)
            busy_cycles <= busy_cycles + 1;
    // Compares one value and counts it.
    task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task final_report;
    begin
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Single-ended unipolar, sleep, then a bipolar word reads it out.
    task test_uni;
    begin
        vin = 12'hA5C;
        sarsc_host_inst.xfer(6'h2F, got);
        check({analog_input_zero_pos, analog_input_one_pos,
            analog_input_one_neg, negative_is_ground}, 4'h9);
        check({range_select, acquiring_out}, 2'h3);
        sarsc_host_inst.convert(1'b0);
        check(sleep_out, 1'b1);
        sarsc_host_inst.xfer(6'h10, got);
        check(got, 12'hA5C);
        check({analog_input_one_pos, negative_is_ground,
            range_select}, 3'h4);
        $display("test uni done");
    end
    endtask
    // Bipolar conversion with a restart attempt in flight.
    task test_bip;
        integer n0;
    begin
        vin = 12'h3F1;
        n0 = busy_cycles;
        sarsc_host_inst.convert(1'b1);
        check(busy_out, 1'b0);
        check(busy_cycles - n0, 16'h000D);
        sarsc_host_inst.xfer(6'h22, got);
        check(got, 12'hBF1);
        check({analog_input_zero_pos, analog_input_one_pos,
            analog_input_one_neg, negative_is_ground,
            range_select}, 5'h13);
        $display("test bip done");
    end
    endtask
    // Start drops mid-conversion; the result waits on the pin at the end.
    task test_awake;
    begin
        vin = 12'h801;
        sarsc_host_inst.pulse;
        check({sleep_out, sdo_oe, sdo_out}, 3'h3);
        sarsc_host_inst.xfer(6'h0A, got);
        check(got, 12'h801);
        check({analog_input_zero_pos, analog_input_one_pos,
            analog_input_one_neg, negative_is_ground,
            range_select}, 5'h15);
        $display("test awake done");
    end
    endtask
    // Clock of 100 ns.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Cuts a hang short.
    initial
    begin
        #2000000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    // Reset, the reset state, then the scenarios.
    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        vin = 12'h000;
        reset_n = 1'b0;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        check({busy_out, sleep_out, sdo_oe, dac_code_out}, 15'h1000);
        test_uni;
        test_bip;
        test_awake;
        final_report;
    end
endmodule // testbench
`default_nettype wire
